// file: include/fe_map.svh
`ifndef FE_MAP_SVH
`define FE_MAP_SVH

// Opcodes
`define FE_OP_WRITE_ENABLE_CMD      8'h06
`define FE_OP_SECTOR    8'h20
`define FE_OP_BLK32     8'h52
`define FE_OP_BLK64     8'hd8
`define FE_OP_CHIP_A    8'h60
`define FE_OP_CHIP_B    8'hc7
`define FE_OP_SLEEP     8'hb9
`define FE_OP_RELEASE   8'hab

// Frame lengths in bits
`define FE_BITS_OPCODE  6'h08
`define FE_BITS_ADDR    6'h20
`define FE_BITS_MAX     6'h3f
`define FE_ADDR_FIRST   6'h08

// Address masks for block alignment
`define FE_MASK_SECTOR  24'hfff000
`define FE_MASK_BLK32   24'hff8000
`define FE_MASK_BLK64   24'hff0000
`define FE_BLK64_MSB    19
`define FE_BLK64_LSB    16
`define FE_BP_ALL       4'h5
`define FE_BLK_COUNT    5'h10

// Self-timed durations, in the unit of their name
`define FE_T_SE_US      100
`define FE_T_BE_US      200
`define FE_T_CE_US      400
`define FE_T_DP_NS      3000
`define FE_T_RES1_NS    3000
`define FE_T_RES2_NS    2000
`define FE_CLK_NS       25
`define FE_NS_PER_US    1000

// Arbitrary identification value
`define FE_DEVICE_ID    8'h5a
`define FE_ID_MSB       3'h7

`endif

// file: include/fe_pkg.sv
package fe_pkg;

   typedef enum logic [1:0] {
      FE_KIND_SECTOR,
      FE_KIND_BLK32,
      FE_KIND_BLK64,
      FE_KIND_CHIP
   } fe_kind_e;

   typedef enum logic [2:0] {
      FE_PH_STANDBY,
      FE_PH_ERASE,
      FE_PH_SLEEP_WAIT,
      FE_PH_SLEEP,
      FE_PH_RESUME
   } fe_phase_e;

   // One erase request handed to the array
   typedef struct packed {
      fe_kind_e    kind;
      logic [23:0] base;
   } fe_erase_s;

   // Serial output pin group
   typedef struct packed {
      logic so;
      logic so_oe_n;
   } fe_so_s;

endpackage

// file: verilog/fe_erase_ctrl.sv
// Behaviour
// - Sector wipe is 20H plus three address bytes, needs the write enable latch.
// - Any address inside a sector wipes that whole sector.
// - Select must rise right after the last address bit, else discard.
// - Valid sector wipe starts tSE cycle; busy flag high during it.
// - Write enable latch clears on the same clock edge that ends each erase cycle.
// - Sector wipe on a protected sector is not executed.
// - 32KB block erase is 52H plus address, needs latch, erases block.
// - 64KB block erase is D8H plus address, needs latch, erases block.
// - Block erases run tBE with busy flag; protected blocks refused.
// - Chip clear is 60H or C7H alone, exact framing, runs tCE.
// - Chip clear runs only when all four protect bits are zero.
// - Deep sleep only via B9H alone with exact framing.
// - In deep sleep every command except release is ignored.
// - Deep sleep is entered tDP after select rises.
// - Deep sleep command during a busy cycle is rejected.
// - Select high without a cycle means standby; reset lands in standby.
// - Release ABH alone, then select high for tRES1 before resuming.
// - ABH with three dummy bytes shifts device ID out MSB first, repeating.
// - Release with ID read waits tRES2 before resuming.
// - Release command ignored while busy; running cycle untouched.
`timescale 1ns/1ps
`include "fe_map.svh"

module fe_erase_ctrl #(
   parameter int unsigned T_SE_US = `FE_T_SE_US, // Sector wipe time
   parameter int unsigned T_BE_US = `FE_T_BE_US, // Block erase time
   parameter int unsigned T_CE_US = `FE_T_CE_US  // Chip clear time
) (
   input  wire  logic             sys_clk,               // 40 MHz clock
   input  wire  logic             reset_n,               // Async reset, low
   input  wire  logic             cs_n,                  // Chip select pin
   input  wire  logic             sclk,                  // Serial clock pin
   input  wire  logic             si,                    // Serial input pin
   input  wire  logic [3:0]       block_protect,         // bit3..bit0 protect
   output       fe_pkg::fe_so_s   so_pin,                // Serial output group
   output       logic             write_enable_latch,    // Latch state
   output       logic             write_in_progress_flag,// Erase running
   output       logic             deep_sleep,            // Lowest power mode
   output       logic             erase_start,           // One-cycle start pulse
   output       fe_pkg::fe_erase_s erase_req             // Erase kind and base
);
   import fe_pkg::*;

   // Cycle counts derived from the times; long ones round down, short round up
   localparam int unsigned SE_CYC = T_SE_US * `FE_NS_PER_US / `FE_CLK_NS;
   localparam int unsigned BE_CYC = T_BE_US * `FE_NS_PER_US / `FE_CLK_NS;
   localparam int unsigned CE_CYC = T_CE_US * `FE_NS_PER_US / `FE_CLK_NS;
   localparam int unsigned DP_CYC = (`FE_T_DP_NS + `FE_CLK_NS - 1) / `FE_CLK_NS;
   localparam int unsigned RES1_CYC = (`FE_T_RES1_NS + `FE_CLK_NS - 1) / `FE_CLK_NS;
   localparam int unsigned RES2_CYC = (`FE_T_RES2_NS + `FE_CLK_NS - 1) / `FE_CLK_NS;

   logic [2:0]  cs_sync_ff;
   logic [2:0]  sclk_sync_ff;
   logic [1:0]  si_sync_ff;
   logic        cs_rise;
   logic        cs_fall;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        selected;
   logic [5:0]  bit_cnt_ff;
   logic [7:0]  op_ff;
   logic [23:0] addr_ff;
   logic [2:0]  id_idx_ff;
   logic        so_ff;
   logic        so_oe_n_ff;
   fe_phase_e   phase_ff;
   logic [31:0] timer_ff;
   logic        wel_ff;
   fe_erase_s   req_ff;
   logic        start_ff;
   logic        exact_op;
   logic        exact_addr;
   logic        is_block_cmd;
   logic        prot_hit;
   logic [4:0]  prot_span;
   logic [3:0]  blk_idx;
   logic        accept_erase;
   logic        accept_sleep;
   logic        accept_release;
   logic        id_mode;
   fe_kind_e    kind_now;
   logic [23:0] base_now;
   logic [31:0] erase_cyc;

   // Two flops per pin before anything looks; third flop keeps edge history
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cs_sync_ff   <= 3'h7;
         sclk_sync_ff <= 3'h0;
         si_sync_ff   <= 2'h0;
      end
      else
      begin
         cs_sync_ff   <= {cs_sync_ff[1:0], cs_n};
         sclk_sync_ff <= {sclk_sync_ff[1:0], sclk};
         si_sync_ff   <= {si_sync_ff[0], si};
      end
   end

   // Edges seen only from the settled flops
   assign cs_rise   = cs_sync_ff[1] & ~cs_sync_ff[2];
   assign cs_fall   = ~cs_sync_ff[1] & cs_sync_ff[2];
   assign selected  = ~cs_sync_ff[1];
   assign sclk_rise = selected & sclk_sync_ff[1] & ~sclk_sync_ff[2];
   assign sclk_fall = selected & ~sclk_sync_ff[1] & sclk_sync_ff[2];

   // Bit counter saturates so long frames never alias to a legal length
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         bit_cnt_ff <= 6'h00;
      else if (cs_fall)
         bit_cnt_ff <= 6'h00;
      else if (sclk_rise && bit_cnt_ff != `FE_BITS_MAX)
         bit_cnt_ff <= bit_cnt_ff + 6'h01;
   end

   // Opcode then address, shifted in on rising serial clock
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         op_ff   <= 8'h00;
         addr_ff <= 24'h000000;
      end
      else if (sclk_rise && bit_cnt_ff < `FE_ADDR_FIRST)
         op_ff <= {op_ff[6:0], si_sync_ff[1]};
      else if (sclk_rise && bit_cnt_ff < `FE_BITS_ADDR)
         addr_ff <= {addr_ff[22:0], si_sync_ff[1]};
   end

   // Framing checks on the rising select edge
   assign exact_op   = (bit_cnt_ff == `FE_BITS_OPCODE);
   assign exact_addr = (bit_cnt_ff == `FE_BITS_ADDR);
   assign is_block_cmd = (op_ff == `FE_OP_SECTOR) || (op_ff == `FE_OP_BLK32)
                       || (op_ff == `FE_OP_BLK64);

   // Protect bits cover the top 2^(n-1) of the 64KB blocks; five or more cover all
   assign blk_idx = addr_ff[`FE_BLK64_MSB:`FE_BLK64_LSB];
   always_comb
   begin
      prot_span = 5'h00;
      if (block_protect >= `FE_BP_ALL)
         prot_span = `FE_BLK_COUNT;
      else if (block_protect != 4'h0)
         prot_span = 5'(5'h01 << (block_protect - 4'h1));
      prot_hit = ({1'b0, blk_idx} >= 5'(`FE_BLK_COUNT - prot_span)) &&
                 (prot_span != 5'h00);
   end

   // Erase kind, aligned base and duration from the opcode
   always_comb
   begin
      kind_now  = FE_KIND_CHIP;
      base_now  = 24'h000000;
      erase_cyc = CE_CYC;
      if (op_ff == `FE_OP_SECTOR)
      begin
         kind_now  = FE_KIND_SECTOR;
         base_now  = addr_ff & `FE_MASK_SECTOR;
         erase_cyc = SE_CYC;
      end
      else if (op_ff == `FE_OP_BLK32)
      begin
         kind_now  = FE_KIND_BLK32;
         base_now  = addr_ff & `FE_MASK_BLK32;
         erase_cyc = BE_CYC;
      end
      else if (op_ff == `FE_OP_BLK64)
      begin
         kind_now  = FE_KIND_BLK64;
         base_now  = addr_ff & `FE_MASK_BLK64;
         erase_cyc = BE_CYC;
      end
   end

   // Acceptance; busy and resume gate all commands off, sleep all but release
   assign accept_erase = cs_rise && phase_ff == FE_PH_STANDBY && wel_ff &&
      ((is_block_cmd && exact_addr && !prot_hit) ||
       ((op_ff == `FE_OP_CHIP_A || op_ff == `FE_OP_CHIP_B) && exact_op &&
        block_protect == 4'h0));
   assign accept_sleep = cs_rise && phase_ff == FE_PH_STANDBY &&
      op_ff == `FE_OP_SLEEP && exact_op;
   assign accept_release = cs_rise && phase_ff == FE_PH_SLEEP &&
      op_ff == `FE_OP_RELEASE && bit_cnt_ff >= `FE_BITS_OPCODE;

   // Self-timed phases; reset always lands in standby
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         phase_ff <= FE_PH_STANDBY;
         timer_ff <= 32'h0;
      end
      else
      begin
         case (phase_ff)
            FE_PH_STANDBY:
               if (accept_erase)
               begin
                  phase_ff <= FE_PH_ERASE;
                  timer_ff <= erase_cyc - 32'h1;
               end
               else if (accept_sleep)
               begin
                  phase_ff <= FE_PH_SLEEP_WAIT;
                  timer_ff <= 32'(DP_CYC - 1);
               end
            FE_PH_ERASE, FE_PH_SLEEP_WAIT:
               if (timer_ff == 32'h0)
                  phase_ff <= (phase_ff == FE_PH_ERASE) ? FE_PH_STANDBY : FE_PH_SLEEP;
               else
                  timer_ff <= timer_ff - 32'h1;
            FE_PH_SLEEP:
               if (accept_release)
               begin
                  phase_ff <= FE_PH_RESUME;
                  timer_ff <= exact_op ? 32'(RES1_CYC - 1) : 32'(RES2_CYC - 1);
               end
            FE_PH_RESUME:
               if (timer_ff == 32'h0)
                  phase_ff <= FE_PH_STANDBY;
               else
                  timer_ff <= timer_ff - 32'h1;
            default:
               phase_ff <= FE_PH_STANDBY;
         endcase
      end
   end

   // Write enable latch; cleared only by reset or as an erase ends, never on a refusal
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         wel_ff <= 1'b0;
      else if (phase_ff == FE_PH_ERASE && timer_ff == 32'h0)
         wel_ff <= 1'b0;
      else if (cs_rise && phase_ff == FE_PH_STANDBY && op_ff == `FE_OP_WRITE_ENABLE_CMD && exact_op)
         wel_ff <= 1'b1;
   end

   // Erase request to the array, held until the next one
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         req_ff   <= '0;
         start_ff <= 1'b0;
      end
      else
      begin
         start_ff <= accept_erase;
         if (accept_erase)
            req_ff <= '{kind: kind_now, base: base_now};
      end
   end

   // ID shifts out only for ABH past three dummy bytes, never while busy
   assign id_mode = op_ff == `FE_OP_RELEASE && bit_cnt_ff >= `FE_BITS_ADDR &&
      (phase_ff == FE_PH_STANDBY || phase_ff == FE_PH_SLEEP);

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         so_ff      <= 1'b0;
         so_oe_n_ff <= 1'b1;
         id_idx_ff  <= `FE_ID_MSB;
      end
      else if (!selected)
      begin
         so_oe_n_ff <= 1'b1;
         id_idx_ff  <= `FE_ID_MSB;
      end
      else if (sclk_fall && id_mode)
      begin
         so_ff      <= 1'(`FE_DEVICE_ID >> id_idx_ff);
         so_oe_n_ff <= 1'b0;
         id_idx_ff  <= id_idx_ff - 3'h1;                // Wraps to repeat the ID
      end
   end

   assign so_pin                 = '{so: so_ff, so_oe_n: so_oe_n_ff};
   assign write_enable_latch     = wel_ff;
   assign write_in_progress_flag = (phase_ff == FE_PH_ERASE);
   assign deep_sleep             = (phase_ff == FE_PH_SLEEP);
   assign erase_start            = start_ff;
   assign erase_req              = req_ff;

   // Erase start needs the latch to have been set
   erase_needs_wel_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      erase_start |-> $past(wel_ff))
      else $error("erase started without write enable");

   // Late or early select rise on block command never starts
   block_framing_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      cs_rise && is_block_cmd && !exact_addr |=> !start_ff)
      else $error("misframed erase started");

   // Busy flag and start pulse both rise the cycle after acceptance
   busy_follows_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      accept_erase |=> write_in_progress_flag && erase_start)
      else $error("busy flag not raised");

   // Latch gone when busy drops
   wel_cleared_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $fell(write_in_progress_flag) |-> !write_enable_latch)
      else $error("latch still set after erase");

   // Protected region never erased
   protect_block_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      cs_rise && prot_hit && is_block_cmd |=> !start_ff)
      else $error("protected region erased");

   // Chip clear only with all protect bits clear
   chip_protect_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      erase_start && erase_req.kind == FE_KIND_CHIP |-> $past(block_protect) == 4'h0)
      else $error("chip clear while protected");

   // Sleep command during an erase never starts the wait phase
   sleep_reject_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      write_in_progress_flag && cs_rise |=> phase_ff != FE_PH_SLEEP_WAIT)
      else $error("sleep entered during erase");

   // Sleep only after the wait phase
   sleep_entry_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(deep_sleep) |-> $past(phase_ff) == FE_PH_SLEEP_WAIT)
      else $error("sleep entered without wait");

   // Release never acts while busy and output stays off
   release_busy_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      write_in_progress_flag |-> !id_mode)
      else $error("id output during erase");

   // Sleep ignores erase commands
   sleep_ignore_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      deep_sleep |=> !erase_start)
      else $error("erase started while asleep");

endmodule

// file: tb/fe_host_model.sv
`timescale 1ns/1ps
// SPI host, mode 0; the link clock stands still low outside frames
module fe_host_model (
   input  wire logic sys_clk, // Bench clock
   input  wire logic so,      // Data from device
   output logic      cs_n,    // Chip select, idle high
   output logic      sclk,    // Link clock, 200 ns period
   output logic      si       // Data to device
);
   // Idle levels from time zero
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si   = 1'b0;
   end

   // Wait n bench clock edges
   task automatic ticks(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // One frame of n bits MSB first; the last 8 bits seen on so land in rx
   task automatic xfer(input logic [47:0] d, input int n, output logic [7:0] rx);
      rx = 8'h00;
      @(posedge sys_clk);
      cs_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         si <= d[i];
         ticks(4);
         sclk <= 1'b1;
         rx = {rx[6:0], so};
         ticks(4);
         sclk <= 1'b0;
      end
      ticks(4);
      cs_n <= 1'b1;
      si   <= ~si; // Released line must not show stale data
      ticks(8); // Deselect gap, above the 4-cycle minimum
   endtask
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
`include "fe_map.svh"
module tb;
   import fe_pkg::*;
   logic       sys_clk;
   logic       reset_n;
   logic       cs_n;
   logic       sclk;
   logic       si;
   logic [3:0] block_protect;
   fe_so_s     so_pin;
   logic       we_latch;
   logic       busy;
   logic       deep_sleep;
   logic       erase_start;
   fe_erase_s  erase_req;
   logic [7:0] rx;
   int         miscompares;
   int         checks_done;
   int         starts;
   int         busy_len;

   // Bench clock, 25 ns
   initial sys_clk = 1'b0;
   always #12.5 sys_clk = ~sys_clk;

   // Short erase times keep the run brief: 40, 80 and 200 cycles
   fe_erase_ctrl #(.T_SE_US(1), .T_BE_US(2), .T_CE_US(5)) i_dut (
      .sys_clk                (sys_clk),
      .reset_n                (reset_n),
      .cs_n                   (cs_n),
      .sclk                   (sclk),
      .si                     (si),
      .block_protect          (block_protect),
      .so_pin                 (so_pin),
      .write_enable_latch     (we_latch),
      .write_in_progress_flag (busy),
      .deep_sleep             (deep_sleep),
      .erase_start            (erase_start),
      .erase_req              (erase_req)
   );

   fe_host_model i_host (
      .sys_clk (sys_clk),
      .so      (so_pin.so),
      .cs_n    (cs_n),
      .sclk    (sclk),
      .si      (si)
   );

   // Count erase starts and the busy span of the latest one
   always @(posedge sys_clk)
   begin
      if (erase_start === 1'b1)
         starts++;
      busy_len = (erase_start === 1'b1) ? 0 : busy_len + int'(busy === 1'b1);
   end

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic compare(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      compare({31'h0, got}, {31'h0, exp});
   endtask

   task automatic check_req(input fe_erase_s got, input fe_erase_s exp);
      compare({6'h0, got}, {6'h0, exp});
   endtask

   task automatic frame(input logic [47:0] d, input int n);
      i_host.xfer(d, n, rx);
   endtask

   task automatic write_enable_cmd();
      frame(`FE_OP_WRITE_ENABLE_CMD, 8);
   endtask

   // Bounded wait for the self-timed cycle to end
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 2000)
      begin
         @(posedge sys_clk);
         n++;
      end
      if (n == 2000)
         miscompares++;
   endtask

   // Accepted erase: start pulse, request, busy span, latch cleared
   task automatic do_erase(input logic [47:0] d, input int n, input fe_erase_s exp, input int len);
      int s0;
      s0 = starts;
      write_enable_cmd();
      check_bit(we_latch, 1'b1);
      frame(d, n);
      check_bit(busy, 1'b1);
      check_req(erase_req, exp);
      wait_idle();
      compare(starts, s0 + 1);
      check_bit(busy_len >= len - 2 && busy_len <= len + 1, 1'b1);
      check_bit(we_latch, 1'b0);
   endtask

   // Refused erase: nothing starts, latch kept
   task automatic refused(input logic [47:0] d, input int n);
      int s0;
      s0 = starts;
      write_enable_cmd();
      frame(d, n);
      i_host.ticks(4);
      compare(starts, s0);
      check_bit(busy, 1'b0);
      check_bit(we_latch, 1'b1);
   endtask

   // Hang guard, well beyond the expected 10k cycles
   initial
   begin
      #1000000;
      miscompares++;
      print_verdict();
   end

   // Main sequence
   initial
   begin
      reset_n = 1'b0;
      block_protect = 4'h0;
      miscompares = 0;
      checks_done = 0;
      starts = 0;
      busy_len = 0;
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      i_host.ticks(4);
      check_bit(we_latch, 1'b0);
      check_bit(deep_sleep, 1'b0);
      check_bit(so_pin.so_oe_n, 1'b1);
      frame({16'h0, `FE_OP_SECTOR, 24'h012345}, 32);
      compare(starts, 0);
      do_erase({16'h0, `FE_OP_SECTOR, 24'h012345}, 32, {FE_KIND_SECTOR, 24'h012000}, 40);
      do_erase({16'h0, `FE_OP_BLK32, 24'h03abcd}, 32, {FE_KIND_BLK32, 24'h038000}, 80);
      refused({16'h0, `FE_OP_SECTOR, 24'h012345} >> 1, 31);
      refused({16'h0, `FE_OP_SECTOR, 24'h012345} << 1, 33);
      block_protect <= 4'h1;
      refused({16'h0, `FE_OP_SECTOR, 24'h0f1234}, 32);
      refused({16'h0, `FE_OP_BLK32, 24'h0f8000}, 32);
      refused({40'h0, `FE_OP_CHIP_A}, 8);
      do_erase({16'h0, `FE_OP_BLK64, 24'h0e7654}, 32, {FE_KIND_BLK64, 24'h0e0000}, 80);
      block_protect <= 4'h3;
      refused({16'h0, `FE_OP_SECTOR, 24'h0c1000}, 32);
      do_erase({16'h0, `FE_OP_SECTOR, 24'h0b1fff}, 32, {FE_KIND_SECTOR, 24'h0b1000}, 40);
      block_protect <= 4'h5;
      refused({16'h0, `FE_OP_BLK64, 24'h000000}, 32);
      block_protect <= 4'h0;
      refused({32'h0, `FE_OP_CHIP_A, 8'h00}, 16);
      do_erase({40'h0, `FE_OP_CHIP_A}, 8, {FE_KIND_CHIP, 24'h0}, 200);
      do_erase({40'h0, `FE_OP_CHIP_B}, 8, {FE_KIND_CHIP, 24'h0}, 200);
      // Sleep and release sent while a chip clear runs
      write_enable_cmd();
      frame({40'h0, `FE_OP_CHIP_A}, 8);
      frame({40'h0, `FE_OP_SLEEP}, 8);
      frame({40'h0, `FE_OP_RELEASE}, 8);
      check_bit(busy, 1'b1);
      wait_idle();
      check_bit(busy_len >= 198 && busy_len <= 201, 1'b1);
      i_host.ticks(140);
      check_bit(deep_sleep, 1'b0);
      frame({40'h0, `FE_OP_SLEEP} << 1, 9);
      i_host.ticks(140);
      check_bit(deep_sleep, 1'b0);
      frame({40'h0, `FE_OP_SLEEP}, 8);
      i_host.ticks(100);
      check_bit(deep_sleep, 1'b0);
      i_host.ticks(30);
      check_bit(deep_sleep, 1'b1);
      write_enable_cmd();
      check_bit(we_latch, 1'b0);
      frame({40'h0, `FE_OP_RELEASE}, 8);
      check_bit(deep_sleep, 1'b0);
      write_enable_cmd();
      check_bit(we_latch, 1'b0);
      i_host.ticks(130);
      write_enable_cmd();
      check_bit(we_latch, 1'b1);
      frame({40'h0, `FE_OP_SLEEP}, 8);
      i_host.ticks(130);
      check_bit(deep_sleep, 1'b1);
      i_host.xfer({`FE_OP_RELEASE, 40'h0}, 48, rx);
      compare({24'h0, rx}, {24'h0, `FE_DEVICE_ID});
      check_bit(deep_sleep, 1'b0);
      i_host.ticks(90);
      do_erase({16'h0, `FE_OP_SECTOR, 24'h0f0fff}, 32, {FE_KIND_SECTOR, 24'h0f0000}, 40);
      // Reset cuts an erase short; the host repeats it
      write_enable_cmd();
      frame({16'h0, `FE_OP_SECTOR, 24'h001000}, 32);
      reset_n <= 1'b0;
      i_host.ticks(2);
      check_bit(busy, 1'b0);
      check_bit(we_latch, 1'b0);
      reset_n <= 1'b1;
      i_host.ticks(4);
      do_erase({16'h0, `FE_OP_SECTOR, 24'h001000}, 32, {FE_KIND_SECTOR, 24'h001000}, 40);
      print_verdict();
   end
endmodule
